// ---- board_ctl_pkg.sv ----
// constants, register indices and types for the board control register bank
`default_nettype none
package board_ctl_pkg;
	localparam int CLK_HZ     = 200_000_000;
	// fast-mode rate keeps one word transfer near 25k cycles
	localparam int I2C_HZ     = 400_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int TICK_CYC   = CLK_HZ / (4 * I2C_HZ);
	localparam int TICK_W     = 9;
	localparam int LED_FLASH_MS = 10;
	localparam int EE_WRITE_MS  = 5;

	localparam logic [15:0] IDX_SHADOW_BASE = 16'h0200;
	localparam logic [15:0] IDX_SHADOW_LAST = 16'h027e;
	localparam logic [15:0] IDX_SHADOW_STAT = 16'h027f;
	localparam logic [15:0] IDX_LOAD_CMD    = 16'h0280;
	localparam logic [15:0] IDX_CLK_SKEW    = 16'h0281;
	localparam logic [15:0] IDX_PIX_LED     = 16'h0282;
	localparam logic [15:0] IDX_SYNC_LINK   = 16'h0283;
	localparam logic [15:0] IDX_EXT_DATA    = 16'h0286;
	localparam logic [15:0] IDX_PIX_CNT     = 16'h0290;
	localparam logic [15:0] IDX_MSG_CNT     = 16'h0291;
	localparam logic [15:0] IDX_CMD_LO      = 16'h0200;
	localparam logic [15:0] IDX_CMD_HI      = 16'h02ff;
	localparam logic [15:0] IDX_PGM_BASE    = 16'h1000;
	localparam logic [15:0] IDX_PGM_LAST    = 16'h13ff;
	localparam logic [15:0] IDX_PAT_BASE    = 16'h4000;
	localparam logic [15:0] IDX_PAT_LAST    = 16'h4fff;
	localparam logic [15:0] IDX_SEQ_LED     = 16'hfff9;

	localparam int SHADOW_WORDS = 127;
	localparam int PGM_WORDS    = 1024;
	localparam int PAT_WORDS    = 4096;
	localparam logic [6:0] LAST_WORD = 7'h7e;
	localparam logic [2:0] BOOT_DEV  = 3'h0;
	localparam logic [3:0] EE_TYPE   = 4'ha;

	// i2c step numbers for write-back and load sequences
	localparam logic [2:0] STP_START  = 3'h0;
	localparam logic [2:0] STP_CTRL   = 3'h1;
	localparam logic [2:0] STP_WADDR  = 3'h2;
	localparam logic [2:0] STP_WHI    = 3'h3;
	localparam logic [2:0] STP_WLO    = 3'h4;
	localparam logic [2:0] STP_WSTOP  = 3'h5;
	localparam logic [2:0] STP_WWAIT  = 3'h6;
	localparam logic [2:0] STP_RSTART = 3'h3;
	localparam logic [2:0] STP_RCTRL  = 3'h4;
	localparam logic [2:0] STP_RHI    = 3'h5;
	localparam logic [2:0] STP_RLO    = 3'h6;
	localparam logic [2:0] STP_RSTOP  = 3'h7;
	localparam logic [3:0] LAST_BIT   = 4'h8;

	typedef enum logic [2:0] {
		I2C_IDLE, I2C_START, I2C_BYTE, I2C_STOP, I2C_WAIT
	} i2c_state_t;
endpackage
`default_nettype wire

// ---- board_control_register_bank.sv ----
// board control register bank: eeprom shadow, skew, leds, links, counters
//
// Added by the designer: the APB slave port and the address map.
`default_nettype none
module board_control_register_bank
	import board_ctl_pkg::*;
#(
	parameter int LED_FLASH_CYC = LED_FLASH_MS * CYC_PER_MS,
	parameter int EE_WRITE_CYC  = EE_WRITE_MS * CYC_PER_MS
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [17:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_scl_i,
	output logic             o_scl_o,
	output logic             o_scl_oe_n,
	input  wire logic        i_sda_i,
	output logic             o_sda_o,
	output logic             o_sda_oe_n,
	output logic      [4:0]  o_sys_clk_skew,
	output logic      [3:0]  o_sync_clk_skew,
	input  wire logic        i_sync_link_in,
	output logic             o_sync_link_out,
	output logic      [3:0]  o_ext_data,
	input  wire logic        i_out_word_wr,
	input  wire logic        i_out_word_sync,
	input  wire logic        i_host_word_rx,
	input  wire logic        i_host_bus_req,
	input  wire logic        i_seq_bus_req,
	output logic             o_pix_led,
	output logic             o_seq_led,
	input  wire logic        i_seq_enable,
	input  wire logic [11:0] i_pgm_rd_addr,
	output logic      [3:0]  o_pgm_slice,
	input  wire logic [10:0] i_pat_rd_addr,
	output logic      [31:0] o_pat_word
);
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        link_up;
		i2c_state_t  st;
		logic [1:0]  ph;
		logic [3:0]  bitn;
		logic [2:0]  step;
		logic [6:0]  word;
		logic [8:0]  sh;
		logic [7:0]  hi_byte;
		logic        rx;
		logic [TICK_W-1:0] tick;
		logic [31:0] wait_cnt;
		logic        writing;
		logic        err;
		logic        valid;
		logic        busy;
		logic [2:0]  dev;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic        pin_lvl;
		logic        sda_s1;
		logic        sda_s2;
		logic [8:0]  skew;
		logic [2:0]  pix_sel;
		logic [2:0]  seq_sel;
		logic        sync_out;
		logic        sync_s1;
		logic        sync_s2;
		logic [3:0]  ext;
		logic [31:0] pix_cnt;
		logic [31:0] msg_cnt;
		logic [31:0] pix_t;
		logic [31:0] seq_t;
		logic [2:0]  pix_ev_q;
		logic [2:0]  seq_ev_q;
		logic        pix_led;
		logic        seq_led;
	} state_t;

	state_t s_q, s_d;

	logic [15:0] shadow_mem [0:SHADOW_WORDS-1];
	logic [15:0] pgm_mem    [0:PGM_WORDS-1];
	logic [15:0] pat_mem    [0:PAT_WORDS-1];
	logic [15:0] pgm_rd_word;

	logic        eng_we;
	logic [15:0] eng_wd;
	logic        host_wr;
	logic [15:0] idx;

	assign idx = i_paddr[17:2];

	// picks the element that a step of the sequence starts with
	function automatic state_t launch(input state_t x, input logic [15:0] wd);
		state_t y;
		y = x;
		y.ph = '0;
		y.bitn = '0;
		y.rx = 1'b0;
		y.st = I2C_BYTE;
		y.sh = '1;
		if (x.writing) begin
			case (x.step)
				STP_START: y.st = I2C_START;
				STP_CTRL:  y.sh = {EE_TYPE, x.dev, 1'b0, 1'b1};
				STP_WADDR: y.sh = {x.word, 1'b0, 1'b1};
				STP_WHI:   y.sh = {wd[15:8], 1'b1};
				STP_WLO:   y.sh = {wd[7:0], 1'b1};
				STP_WSTOP: y.st = I2C_STOP;
				default: begin
					y.st = I2C_WAIT;
					y.wait_cnt = 32'(EE_WRITE_CYC - 1);
				end
			endcase
		end else begin
			case (x.step)
				STP_START, STP_RSTART: y.st = I2C_START;
				STP_CTRL:  y.sh = {EE_TYPE, x.dev, 1'b0, 1'b1};
				STP_WADDR: y.sh = {x.word, 1'b0, 1'b1};
				STP_RCTRL: y.sh = {EE_TYPE, x.dev, 1'b1, 1'b1};
				STP_RHI: begin
					y.rx = 1'b1;
					y.sh = {8'hff, 1'b0};
				end
				STP_RLO: begin
					y.rx = 1'b1;
					y.sh = {8'hff, 1'b1};
				end
				default: y.st = I2C_STOP;
			endcase
		end
		return y;
	endfunction

	always_comb begin
		logic        setup;
		logic        acc;
		logic        tick_en;
		logic        nxt;
		logic        in_sh;
		logic        in_pgm;
		logic        in_pat;
		logic        pix_trig;
		logic        seq_trig;
		logic [2:0]  pix_ev;
		logic [2:0]  seq_ev;
		logic [31:0] rd;
		logic        bad;
		setup = i_psel & ~i_penable;
		acc = i_psel & i_penable & s_q.pready;
		tick_en = 1'b0;
		nxt = 1'b0;
		in_sh = (idx >= IDX_SHADOW_BASE) && (idx <= IDX_SHADOW_LAST);
		in_pgm = (idx >= IDX_PGM_BASE) && (idx <= IDX_PGM_LAST);
		in_pat = (idx >= IDX_PAT_BASE) && (idx <= IDX_PAT_LAST);
		rd = '0;
		bad = 1'b0;
		pix_ev = '0;
		seq_ev = '0;
		pix_trig = 1'b0;
		seq_trig = 1'b0;
		eng_we = 1'b0;
		eng_wd = '0;
		host_wr = acc & i_pwrite & ~s_q.pslverr;
		s_d = s_q;

		// two flops before any logic reads the sda or sync link pin
		s_d.sda_s1 = i_sda_i;
		s_d.sda_s2 = s_q.sda_s1;
		s_d.sync_s1 = i_sync_link_in;
		s_d.sync_s2 = s_q.sync_s1;

		// zero-wait apb slave: decode in setup, answer in access
		s_d.pready = setup;
		if (setup) begin
			if (in_sh) begin
				rd = {16'h0000, shadow_mem[idx[6:0]]};
			end else if (in_pgm) begin
				rd = {16'h0000, pgm_mem[idx[9:0]]};
				bad = i_seq_enable;
			end else if (in_pat) begin
				rd = {16'h0000, pat_mem[idx[11:0]]};
			end else begin
				case (idx)
					IDX_SHADOW_STAT: rd = {16'h0000, s_q.busy, s_q.valid,
						(s_q.st == I2C_START) || (s_q.st == I2C_BYTE) ||
						(s_q.st == I2C_STOP),
						(s_q.st == I2C_BYTE) && s_q.rx, 1'b0, s_q.word,
						1'b0, s_q.dev};
					IDX_LOAD_CMD:  rd = '0;
					IDX_CLK_SKEW:  rd = {23'h000000, s_q.skew};
					IDX_PIX_LED:   rd = {29'h00000000, s_q.pix_sel};
					IDX_SYNC_LINK: rd = {31'h00000000, s_q.sync_s2};
					IDX_EXT_DATA:  rd = '0;
					IDX_PIX_CNT:   rd = s_q.pix_cnt;
					IDX_MSG_CNT:   rd = s_q.msg_cnt;
					IDX_SEQ_LED:   rd = {29'h00000000, s_q.seq_sel};
					// the enables register is deliberately absent here
					default:       bad = 1'b1;
				endcase
			end
			s_d.prdata = rd;
			s_d.pslverr = bad;
		end
		if (acc) begin
			s_d.link_up = 1'b1;
		end
		if (host_wr) begin
			if (in_sh) begin
				s_d.valid = 1'b0;
			end
			case (idx)
				IDX_CLK_SKEW:  s_d.skew = i_pwdata[8:0];
				IDX_PIX_LED:   s_d.pix_sel = i_pwdata[2:0];
				IDX_SEQ_LED:   s_d.seq_sel = i_pwdata[2:0];
				IDX_SYNC_LINK: s_d.sync_out = i_pwdata[0];
				IDX_EXT_DATA:  s_d.ext = i_pwdata[3:0];
				default: ;
			endcase
			// commands arriving while busy are dropped
			if ((idx == IDX_SHADOW_STAT || idx == IDX_LOAD_CMD) && !s_q.busy) begin
				s_d.dev = i_pwdata[2:0];
				s_d.writing = (idx == IDX_SHADOW_STAT);
				s_d.busy = 1'b1;
				s_d.valid = 1'b0;
				s_d.err = 1'b0;
				s_d.word = '0;
				s_d.step = STP_START;
				s_d = launch(s_d, shadow_mem[s_d.word]);
			end
		end

		// counters: an output word in the clearing cycle still counts
		if (host_wr && idx == IDX_PIX_CNT) begin
			s_d.pix_cnt = '0;
		end
		if (host_wr && idx == IDX_MSG_CNT) begin
			s_d.msg_cnt = '0;
		end
		if (i_out_word_wr && !i_out_word_sync) begin
			s_d.pix_cnt = s_d.pix_cnt + 32'h00000001;
		end
		if (i_out_word_wr && i_out_word_sync) begin
			s_d.msg_cnt = s_d.msg_cnt + 32'h00000001;
		end

		// quarter-bit tick for the i2c engine
		if (s_q.st == I2C_IDLE || s_q.tick == TICK_W'(TICK_CYC - 1)) begin
			s_d.tick = '0;
			tick_en = (s_q.st != I2C_IDLE);
		end else begin
			s_d.tick = s_q.tick + 1'b1;
		end
		if (s_q.st == I2C_WAIT) begin
			if (s_q.wait_cnt == '0) begin
				nxt = 1'b1;
			end else begin
				s_d.wait_cnt = s_q.wait_cnt - 32'h00000001;
			end
		end else if (tick_en) begin
			s_d.ph = s_q.ph + 1'b1;
			case (s_q.st)
				I2C_START: begin
					case (s_q.ph)
						2'h0: begin
							s_d.sda_oe_n = 1'b1;
							s_d.scl_oe_n = 1'b1;
						end
						2'h1: s_d.sda_oe_n = 1'b0;
						2'h2: s_d.scl_oe_n = 1'b0;
						default: nxt = 1'b1;
					endcase
				end
				I2C_BYTE: begin
					case (s_q.ph)
						2'h0: begin
							s_d.scl_oe_n = 1'b0;
							s_d.sda_oe_n = s_q.sh[8];
						end
						2'h1: s_d.scl_oe_n = 1'b1;
						2'h2: s_d.sh = {s_q.sh[7:0], s_q.sda_s2};
						default: begin
							s_d.scl_oe_n = 1'b0;
							s_d.bitn = s_q.bitn + 1'b1;
							if (s_q.bitn == LAST_BIT) begin
								if (s_q.rx && s_q.step == STP_RHI) begin
									s_d.hi_byte = s_q.sh[8:1];
									nxt = 1'b1;
								end else if (s_q.rx) begin
									eng_we = 1'b1;
									eng_wd = {s_q.hi_byte, s_q.sh[8:1]};
									nxt = 1'b1;
								end else if (s_q.sh[0]) begin
									// no acknowledge: word stays shown in status
									s_d.err = 1'b1;
									s_d.step = s_q.writing ? STP_WSTOP : STP_RSTOP;
									s_d = launch(s_d, shadow_mem[s_q.word]);
								end else begin
									nxt = 1'b1;
								end
							end
						end
					endcase
				end
				I2C_STOP: begin
					case (s_q.ph)
						2'h0: begin
							s_d.scl_oe_n = 1'b0;
							s_d.sda_oe_n = 1'b0;
						end
						2'h1: s_d.scl_oe_n = 1'b1;
						2'h2: s_d.sda_oe_n = 1'b1;
						default: nxt = 1'b1;
					endcase
				end
				default: ;
			endcase
		end
		if (nxt) begin
			if (s_q.step == (s_q.writing ? STP_WWAIT : STP_RSTOP) || s_q.err) begin
				if (s_q.err || s_q.word == LAST_WORD) begin
					s_d.st = I2C_IDLE;
					s_d.busy = 1'b0;
					s_d.valid = ~s_q.err;
				end else begin
					s_d.word = s_q.word + 1'b1;
					s_d.step = STP_START;
					s_d = launch(s_d, shadow_mem[s_q.word]);
				end
			end else begin
				s_d.step = s_q.step + 1'b1;
				s_d = launch(s_d, shadow_mem[s_q.word]);
			end
		end

		// leds stay lit until the first host transfer completes
		pix_ev = {i_out_word_wr & ~i_out_word_sync,
			i_psel && idx >= IDX_CMD_LO && idx <= IDX_CMD_HI, i_out_word_wr};
		seq_ev = {i_seq_bus_req, i_host_bus_req, i_host_word_rx};
		s_d.pix_ev_q = pix_ev;
		s_d.seq_ev_q = seq_ev;
		pix_trig = |(s_q.pix_sel & pix_ev & ~s_q.pix_ev_q);
		seq_trig = |(s_q.seq_sel & seq_ev & ~s_q.seq_ev_q);
		if (pix_trig) begin
			s_d.pix_t = 32'(LED_FLASH_CYC - 1);
		end else if (s_q.pix_t != '0) begin
			s_d.pix_t = s_q.pix_t - 32'h00000001;
		end
		if (seq_trig) begin
			s_d.seq_t = 32'(LED_FLASH_CYC - 1);
		end else if (s_q.seq_t != '0) begin
			s_d.seq_t = s_q.seq_t - 32'h00000001;
		end
		s_d.pix_led = ~s_q.link_up | pix_trig | (s_q.pix_t != '0);
		s_d.seq_led = ~s_q.link_up | seq_trig | (s_q.seq_t != '0);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.busy <= 1'b1;
			s_q.st <= I2C_START;
			s_q.dev <= BOOT_DEV;
			s_q.scl_oe_n <= 1'b1;
			s_q.sda_oe_n <= 1'b1;
			s_q.pix_led <= 1'b1;
			s_q.seq_led <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// engine writes win over a host write in the same cycle
	always_ff @(posedge i_ref_clk) begin
		if (eng_we) begin
			shadow_mem[s_q.word] <= eng_wd;
		end else if (host_wr && idx >= IDX_SHADOW_BASE &&
			idx <= IDX_SHADOW_LAST) begin
			shadow_mem[idx[6:0]] <= i_pwdata[15:0];
		end
		if (host_wr && idx >= IDX_PGM_BASE && idx <= IDX_PGM_LAST) begin
			pgm_mem[idx[9:0]] <= i_pwdata[15:0];
		end
		if (host_wr && idx >= IDX_PAT_BASE && idx <= IDX_PAT_LAST) begin
			pat_mem[idx[11:0]] <= i_pwdata[15:0];
		end
		o_pgm_slice <= pgm_rd_word[{i_pgm_rd_addr[1:0], 2'b00} +: 4];
		o_pat_word <= {pat_mem[{i_pat_rd_addr, 1'b1}],
			pat_mem[{i_pat_rd_addr, 1'b0}]};
	end
	assign pgm_rd_word = pgm_mem[i_pgm_rd_addr[11:2]];

	assign o_prdata = s_q.prdata;
	assign o_pready = s_q.pready;
	assign o_pslverr = s_q.pslverr;
	assign o_scl_o = s_q.pin_lvl;
	assign o_sda_o = s_q.pin_lvl;
	assign o_scl_oe_n = s_q.scl_oe_n;
	assign o_sda_oe_n = s_q.sda_oe_n;
	assign o_sys_clk_skew = s_q.skew[8:4];
	assign o_sync_clk_skew = s_q.skew[3:0];
	assign o_sync_link_out = s_q.sync_out;
	assign o_ext_data = s_q.ext;
	assign o_pix_led = s_q.pix_led;
	assign o_seq_led = s_q.seq_led;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	logic acc_w;
	assign acc_w = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

	property p_stat_zero;
		i_psel && !i_penable && idx == IDX_SHADOW_STAT |=>
			o_pready && o_prdata[3] == 1'b0 && o_prdata[11] == 1'b0;
	endproperty
	a_stat_zero: assert property (p_stat_zero)
		else $error("status reserved bits not zero");

	property p_skew_reset;
		@(posedge i_ref_clk) i_sys_rst |=> o_sys_clk_skew == '0 &&
			o_sync_clk_skew == '0;
	endproperty
	a_skew_reset: assert property (disable iff (1'b0) p_skew_reset)
		else $error("skew not zero after reset");

	property p_pix_clear;
		acc_w && idx == IDX_PIX_CNT && !i_out_word_wr |=> s_q.pix_cnt == '0;
	endproperty
	a_pix_clear: assert property (p_pix_clear)
		else $error("pixel count not cleared by write");

	property p_msg_inc;
		i_out_word_wr && i_out_word_sync && !acc_w |=>
			s_q.msg_cnt == $past(s_q.msg_cnt) + 32'h00000001;
	endproperty
	a_msg_inc: assert property (p_msg_inc)
		else $error("message count did not step");

	sequence s_pgm_setup;
		i_psel && !i_penable && i_seq_enable && idx >= IDX_PGM_BASE &&
			idx <= IDX_PGM_LAST;
	endsequence
	property p_pgm_block;
		s_pgm_setup |=> o_pready && o_pslverr;
	endproperty
	a_pgm_block: assert property (p_pgm_block)
		else $error("program memory reachable while running");

	property p_led_lit;
		!s_q.link_up |=> o_pix_led && o_seq_led;
	endproperty
	a_led_lit: assert property (p_led_lit)
		else $error("led dark before host contact");

	sequence s_load_cmd;
		acc_w && idx == IDX_LOAD_CMD && !s_q.busy;
	endsequence
	property p_load_start;
		s_load_cmd |=> s_q.busy && !s_q.valid && s_q.st == I2C_START
			##1 s_q.st == I2C_START [*4];
	endproperty
	a_load_start: assert property (p_load_start)
		else $error("load did not start busy and invalid");

	property p_sync_out;
		acc_w && idx == IDX_SYNC_LINK |=> o_sync_link_out == $past(i_pwdata[0]);
	endproperty
	a_sync_out: assert property (p_sync_out)
		else $error("sync link output not updated");

	property p_ext_data;
		acc_w && idx == IDX_EXT_DATA |=> o_ext_data == $past(i_pwdata[3:0]);
	endproperty
	a_ext_data: assert property (p_ext_data)
		else $error("external data not updated");
endmodule
`default_nettype wire

// ---- eeprom_model.sv ----
// behavioural serial eeprom on an open-drain two-wire bus
`default_nettype none
module eeprom_model #(
	parameter logic [2:0] DEV = 3'h5
) (
	input  wire logic i_scl,
	input  wire logic i_sda,
	output logic      o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sh;
	logic [7:0] ptr;
	logic       act;
	logic       rd;
	logic       ack;
	int         bits;
	int         nb;
	initial begin
		o_sda_low = 1'b0;
		act = 1'b0;
		foreach (mem[i]) mem[i] = 8'(i * 7 + 3);
	end
	// start and stop are sda edges while scl is high
	always @(negedge i_sda) if (i_scl) begin
		act = 1'b1;
		bits = 0;
		nb = 0;
		rd = 1'b0;
	end
	always @(posedge i_sda) if (i_scl) act = 1'b0;
	always @(posedge i_scl) if (act) begin
		if (bits < 8) sh = {sh[6:0], i_sda};
		else if (rd && i_sda) act = 1'b0;
		bits++;
	end
	// sda only moves while scl is low, so no false start or stop
	always @(negedge i_scl) if (act) begin
		o_sda_low = 1'b0;
		if (bits == 8) begin
			if (nb == 0) begin
				ack = sh[7:1] == {4'ha, DEV};
				rd = sh[0];
			end else if (nb == 1 && !rd) begin
				ptr = sh;
			end else if (!rd) begin
				mem[ptr] = sh;
				ptr++;
			end
			o_sda_low = ack && !(rd && nb > 0);
			act = ack;
			nb++;
		end else if (bits == 9) begin
			bits = 0;
			if (rd) begin
				sh = mem[ptr];
				ptr++;
			end
		end
		// sh shifts on each rising scl of the eight data bits, so its top bit is always the next one
		if (act && rd && nb > 0 && bits < 8) o_sda_low = !sh[7];
	end
endmodule
`default_nettype wire

// ---- tb_board_control_register_bank.sv ----
// self-checking bench for the board control register bank
`default_nettype none
module tb_board_control_register_bank;
	import board_ctl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [15:0] idx;
		logic [31:0] wd;
		logic [31:0] rd;
		logic        er;
	} row_t;
	localparam int LED_N = 50;
	logic        clk, rst, psel, pen, pwr, pready, pslverr, re;
	logic        scl_o, sda_o, scl_oe_n, sda_oe_n, ee_low, sync_in;
	logic        sync_out, ow_wr, ow_sync, hw_rx, hbr, sbr, seq_en;
	logic        pix_led, seq_led;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rv, pat_w;
	logic [4:0]  sys_skew;
	logic [3:0]  sync_skew, ext, slice;
	logic [11:0] pgm_a;
	logic [10:0] pat_a;
	wire         scl_w = scl_oe_n ? 1'b1 : scl_o;
	wire         sda_w = (sda_oe_n ? 1'b1 : sda_o) & ~ee_low;
	int          err_count, checks;
	row_t        rows[10] = '{
		'{IDX_CLK_SKEW, 32'hfa5, 32'h1a5, 0},
		'{IDX_PIX_LED, 32'hf, 32'h7, 0},
		'{IDX_SEQ_LED, 32'h5, 32'h5, 0},
		'{IDX_SYNC_LINK, 32'h1, 32'h0, 0},
		'{IDX_EXT_DATA, 32'hc, 32'h0, 0},
		'{16'h0210, 32'h1234abcd, 32'habcd, 0},
		'{IDX_SHADOW_LAST, 32'hffff, 32'hffff, 0},
		'{16'h0287, 32'h5, 32'h0, 1},
		'{IDX_PGM_BASE, 32'h5a5a, 32'h5a5a, 0},
		'{IDX_PAT_LAST, 32'h8001, 32'h8001, 0}
	};

	board_control_register_bank #(
		.LED_FLASH_CYC (LED_N),
		.EE_WRITE_CYC  (20)
	) uut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_scl_i(scl_w), .o_scl_o(scl_o),
		.o_scl_oe_n(scl_oe_n), .i_sda_i(sda_w), .o_sda_o(sda_o),
		.o_sda_oe_n(sda_oe_n), .o_sys_clk_skew(sys_skew),
		.o_sync_clk_skew(sync_skew), .i_sync_link_in(sync_in),
		.o_sync_link_out(sync_out), .o_ext_data(ext),
		.i_out_word_wr(ow_wr), .i_out_word_sync(ow_sync),
		.i_host_word_rx(hw_rx), .i_host_bus_req(hbr),
		.i_seq_bus_req(sbr), .o_pix_led(pix_led), .o_seq_led(seq_led),
		.i_seq_enable(seq_en), .i_pgm_rd_addr(pgm_a),
		.o_pgm_slice(slice), .i_pat_rd_addr(pat_a), .o_pat_word(pat_w)
	);
	eeprom_model #(.DEV(3'h5)) ee (
		.i_scl(scl_w), .i_sda(sda_w), .o_sda_low(ee_low)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [15:0] idx,
			input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// read status until the word field reaches w or busy drops
	task automatic poll(input logic [6:0] w);
		int n;
		n = 0;
		do begin
			apb(1'b0, IDX_SHADOW_STAT, 32'h0);
			n++;
		end while (rv[15] === 1'b1 && rv[10:4] !== w && n < 60000);
	endtask

	task automatic pulse(input logic s);
		@(posedge clk);
		ow_wr <= 1'b1;
		ow_sync <= s;
		@(posedge clk);
		ow_wr <= 1'b0;
	endtask

	task automatic lchk(input logic s, input logic e);
		repeat (3) @(posedge clk);
		chk({31'h0, s ? seq_led : pix_led}, {31'h0, e});
		repeat (LED_N) @(posedge clk);
		chk({31'h0, s ? seq_led : pix_led}, 32'h0);
	endtask

	task automatic do_rst();
		rst <= 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({23'h0, sys_skew, sync_skew}, 32'h0);
		chk({30'h0, pix_led, seq_led}, 32'h3);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// two boot loads, one load word, one write-back word and 50 us: ~66k
	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		summarize();
	end

	initial begin
		{psel, pen, pwr, ow_wr, ow_sync, hw_rx, hbr, sbr} = '0;
		{seq_en, sync_in} = '0;
		paddr = '0;
		pwdata = '0;
		pgm_a = '0;
		pat_a = '0;
		err_count = 0;
		checks = 0;
		do_rst();
		apb(1'b0, IDX_SHADOW_STAT, 32'h0);
		chk(rv & 32'hc000, 32'h8000);
		poll(7'h7f);
		chk(rv, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].idx, rows[i].wd);
			chk({31'h0, re}, {31'h0, rows[i].er});
			apb(1'b0, rows[i].idx, 32'h0);
			chk(rv, rows[i].rd);
		end
		chk({18'h0, sys_skew, sync_skew, sync_out, ext},
			{18'h0, 5'h1a, 4'h5, 1'b1, 4'hc});
		// the input pin passes two flops before the register sees it
		sync_in <= 1'b1;
		repeat (2) @(posedge clk);
		apb(1'b0, IDX_SYNC_LINK, 32'h0);
		chk(rv, 32'h1);
		$display("test registers done");
		for (int i = 0; i < 5; i++) pulse(i > 2);
		apb(1'b0, IDX_PIX_CNT, 32'h0);
		chk(rv, 32'h3);
		apb(1'b1, IDX_PIX_CNT, 32'h77);
		apb(1'b0, IDX_PIX_CNT, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, IDX_MSG_CNT, 32'h0);
		chk(rv, 32'h2);
		apb(1'b1, IDX_MSG_CNT, 32'h1);
		apb(1'b0, IDX_MSG_CNT, 32'h0);
		chk(rv, 32'h0);
		$display("test counters done");
		// pixel led select writes sit in the command range, so let that flash die
		apb(1'b1, IDX_PIX_LED, 32'h4);
		repeat (60) @(posedge clk);
		pulse(1'b1);
		lchk(1'b0, 1'b0);
		pulse(1'b0);
		lchk(1'b0, 1'b1);
		apb(1'b1, IDX_PIX_LED, 32'h1);
		repeat (60) @(posedge clk);
		pulse(1'b1);
		lchk(1'b0, 1'b1);
		apb(1'b1, IDX_PIX_LED, 32'h2);
		repeat (60) @(posedge clk);
		apb(1'b0, IDX_SYNC_LINK, 32'h0);
		lchk(1'b0, 1'b1);
		apb(1'b1, IDX_SEQ_LED, 32'h4);
		sbr <= 1'b1;
		lchk(1'b1, 1'b1);
		sbr <= 1'b0;
		apb(1'b1, IDX_SEQ_LED, 32'h1);
		hw_rx <= 1'b1;
		@(posedge clk);
		hw_rx <= 1'b0;
		lchk(1'b1, 1'b1);
		apb(1'b1, IDX_SEQ_LED, 32'h2);
		hbr <= 1'b1;
		lchk(1'b1, 1'b1);
		hbr <= 1'b0;
		$display("test leds done");
		apb(1'b1, 16'h1001, 32'h4321);
		apb(1'b1, 16'h4002, 32'haaaa);
		apb(1'b1, 16'h4003, 32'hbbbb);
		pgm_a <= 12'h006;
		pat_a <= 11'h001;
		repeat (3) @(posedge clk);
		chk({28'h0, slice}, 32'h3);
		chk(pat_w, 32'hbbbbaaaa);
		seq_en <= 1'b1;
		apb(1'b1, IDX_PGM_BASE, 32'h1111);
		chk({31'h0, re}, 32'h1);
		seq_en <= 1'b0;
		apb(1'b0, IDX_PGM_BASE, 32'h0);
		chk(rv, 32'h5a5a);
		$display("test memories done");
		// no temperature channel here: the bank refuses it after the wait
		apb(1'b1, 16'h02c0, 32'h0);
		repeat (10000) @(posedge clk);
		apb(1'b0, 16'h02c0, 32'h0);
		chk({31'h0, re}, 32'h1);
		$display("test temperature done");
		apb(1'b1, IDX_LOAD_CMD, 32'h5);
		apb(1'b0, IDX_SHADOW_STAT, 32'h0);
		chk(rv & 32'hf80f, 32'ha005);
		poll(7'h01);
		chk(rv & 32'hf7f7, 32'ha015);
		apb(1'b0, IDX_SHADOW_BASE, 32'h0);
		chk(rv, 32'h030a);
		$display("test load done");
		do_rst();
		poll(7'h7f);
		chk(rv, 32'h0);
		apb(1'b1, IDX_SHADOW_BASE, 32'hbeef);
		apb(1'b1, IDX_SHADOW_STAT, 32'h5);
		poll(7'h01);
		chk(rv & 32'hf7f7, 32'ha015);
		chk({16'h0, ee.mem[0], ee.mem[1]}, 32'hbeef);
		$display("test write-back done");
		summarize();
	end
endmodule
`default_nettype wire
